//--- hw/ohc_top.sv
// Operating hours counter with AXI4-Lite registers and interrupt.
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module ohc_top #(
  parameter logic [32:0] P_MINUTE_CYCLES = ohc_pkg::MINUTE_CYCLES
) (
  input  wire logic        i_clk_sys,      // System clock, 125 MHz.
  input  wire logic        i_rst_n,        // System reset, active low.
  input  wire logic        i_por_n,        // Retained-value power-on reset, active low.
  input  wire logic        i_en,           // Monitored enable input.
  input  wire logic        i_rst_interval, // Interval reset input.
  input  wire logic        i_clr_all,      // Clear-all input.
  input  wire logic [13:0] i_ext_hours,    // Interval hours from another block.
  input  wire logic [5:0]  i_ext_minutes,  // Interval minutes from another block.
  output logic             o_q,            // Switch output.
  output logic             o_irq,          // Interrupt, level.
  input  wire logic [4:0]  i_awaddr,       // AXI write address.
  input  wire logic        i_awvalid,      // AXI write address valid.
  output logic             o_awready,      // AXI write address ready.
  input  wire logic [31:0] i_wdata,        // AXI write data.
  input  wire logic [3:0]  i_wstrb,        // AXI write strobes.
  input  wire logic        i_wvalid,       // AXI write data valid.
  output logic             o_wready,       // AXI write data ready.
  output logic [1:0]       o_bresp,        // AXI write response.
  output logic             o_bvalid,       // AXI write response valid.
  input  wire logic        i_bready,       // AXI write response ready.
  input  wire logic [4:0]  i_araddr,       // AXI read address.
  input  wire logic        i_arvalid,      // AXI read address valid.
  output logic             o_arready,      // AXI read address ready.
  output logic [31:0]      o_rdata,        // AXI read data.
  output logic [1:0]       o_rresp,        // AXI read response.
  output logic             o_rvalid,       // AXI read data valid.
  input  wire logic        i_rready        // AXI read data ready.
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function automatic logic is_mapped(input logic [4:0] a);
    return (a == ohc_pkg::OFF_CTRL) || (a == ohc_pkg::OFF_INTERVAL) ||
           (a == ohc_pkg::OFF_TOTAL) || (a == ohc_pkg::OFF_REMAIN) ||
           (a == ohc_pkg::OFF_STATUS) || (a == ohc_pkg::OFF_IRQ_STAT) ||
           (a == ohc_pkg::OFF_IRQ_MASK);
  endfunction : is_mapped

  function automatic logic [5:0] clamp_min(input logic [5:0] m);
    return (m > ohc_pkg::MIN_MAX) ? ohc_pkg::MIN_MAX : m;
  endfunction : clamp_min

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta, rst_n_s, por_meta, por_n_s;

  // Both resets assert at once and release through two flip-flops.
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta <= 1'b0;
      rst_n_s  <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n_s  <= rst_meta;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_por_n) begin
    if (!i_por_n) begin
      por_meta <= 1'b0;
      por_n_s  <= 1'b0;
    end else begin
      por_meta <= 1'b1;
      por_n_s  <= por_meta;
    end
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [4:0]  awaddr_reg;
  logic        aw_full, w_full, wr_fire;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic [2:0]  ctrl_reg;
  logic [13:0] iv_hrs_reg;
  logic [5:0]  iv_min_reg;
  logic [1:0]  irq_stat_reg, irq_mask_reg, irq_evt;
  logic [16:0] tot_hrs_reg;
  logic [5:0]  tot_min_reg;
  logic [19:0] remaining_time_reg, iv_prev_reg;
  logic [13:0] iv_hrs;
  logic [5:0]  iv_min;
  logic [19:0] service_interval;
  logic [22:0] total_minutes;
  logic        rint_prev, clr_prev, rint_rise, clr_rise;
  logic        tick, div_start, div_done, q_next, tot_sat, run_bit;
  logic        iv_changed, reload, preset_wr;
  logic [19:0] div_rem;
  logic [31:0] rd_data;
  ohc_pkg::ohc_state_e state_reg;

  assign run_bit = ctrl_reg[ohc_pkg::CTRL_RUN];
  assign wr_fire = aw_full & w_full & ~o_bvalid;

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  // Address and data are caught independently; either may come first.
  always_ff @(posedge i_clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      aw_full    <= 1'b0;
      o_awready  <= 1'b1;
      awaddr_reg <= '0;
    end else if (i_awvalid && o_awready) begin
      aw_full    <= 1'b1;
      o_awready  <= 1'b0;
      awaddr_reg <= i_awaddr;
    end else if (wr_fire) begin
      aw_full    <= 1'b0;
      o_awready  <= 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      w_full    <= 1'b0;
      o_wready  <= 1'b1;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end else if (i_wvalid && o_wready) begin
      w_full    <= 1'b1;
      o_wready  <= 1'b0;
      wdata_reg <= i_wdata;
      wstrb_reg <= i_wstrb;
    end else if (wr_fire) begin
      w_full    <= 1'b0;
      o_wready  <= 1'b1;
    end
  end

  // The response is held until the master takes it, which also blocks the next write.
  always_ff @(posedge i_clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      o_bvalid <= 1'b0;
      o_bresp  <= ohc_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      o_bvalid <= 1'b1;
      o_bresp  <= is_mapped(awaddr_reg) ? ohc_pkg::RESP_OKAY : ohc_pkg::RESP_SLVERR;
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Interval fields are clamped on write so they never leave their range.
  always_ff @(posedge i_clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      ctrl_reg     <= ohc_pkg::CTRL_RST;
      iv_hrs_reg   <= '0;
      iv_min_reg   <= '0;
      irq_mask_reg <= ohc_pkg::IRQ_MASK_RST;
    end else if (wr_fire && wstrb_reg == 4'hF) begin
      unique case (awaddr_reg)
        ohc_pkg::OFF_CTRL: ctrl_reg <= wdata_reg[2:0];
        ohc_pkg::OFF_INTERVAL: begin
          iv_hrs_reg <= (wdata_reg[13:0] > ohc_pkg::IV_HRS_MAX) ? ohc_pkg::IV_HRS_MAX
                                                                  : wdata_reg[13:0];
          iv_min_reg <= clamp_min(wdata_reg[ohc_pkg::IV_MIN_LSB +: 6]);
        end
        ohc_pkg::OFF_IRQ_MASK: irq_mask_reg <= wdata_reg[1:0];
        default: ;
      endcase
    end
  end

  // Events win over a write-one clear in the same cycle.
  always_ff @(posedge i_clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      irq_stat_reg <= '0;
      o_irq        <= 1'b0;
    end else begin
      if (wr_fire && awaddr_reg == ohc_pkg::OFF_IRQ_STAT && wstrb_reg[0]) begin
        irq_stat_reg <= (irq_stat_reg & ~wdata_reg[1:0]) | irq_evt;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_evt;
      end
      o_irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // Effective interval and input edges
  // ----------------------------------------------------------------
  // An out-of-range value from another block is rounded to the nearest valid one.
  assign iv_hrs = ctrl_reg[ohc_pkg::CTRL_EXT] ?
                  ((i_ext_hours > ohc_pkg::IV_HRS_MAX) ? ohc_pkg::IV_HRS_MAX : i_ext_hours)
                  : iv_hrs_reg;
  assign iv_min = ctrl_reg[ohc_pkg::CTRL_EXT] ? clamp_min(i_ext_minutes) : iv_min_reg;
  assign service_interval = 20'({iv_hrs, 6'h00}) - 20'({iv_hrs, 2'h0}) + 20'(iv_min);
  assign total_minutes = 23'({tot_hrs_reg, 6'h00}) - 23'({tot_hrs_reg, 2'h0})
                       + 23'(tot_min_reg);

  assign rint_rise  = i_rst_interval & ~rint_prev;
  assign clr_rise   = i_clr_all & ~clr_prev;
  assign iv_changed = (state_reg == ohc_pkg::OHC_RUN) && (service_interval != iv_prev_reg);
  assign reload     = rint_rise | clr_rise | iv_changed;
  assign preset_wr  = wr_fire && awaddr_reg == ohc_pkg::OFF_TOTAL && wstrb_reg == 4'hF &&
                      !run_bit && state_reg == ohc_pkg::OHC_STOP;
  assign tot_sat    = (tot_hrs_reg == ohc_pkg::TOT_HRS_MAX);

  // Previous input levels and interval for edge and change detection.
  always_ff @(posedge i_clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      rint_prev   <= 1'b0;
      clr_prev    <= 1'b0;
      iv_prev_reg <= '0;
    end else begin
      rint_prev   <= i_rst_interval;
      clr_prev    <= i_clr_all;
      iv_prev_reg <= service_interval;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer: stop, start-up calculation, run
  // ----------------------------------------------------------------
  assign div_start = (state_reg == ohc_pkg::OHC_STOP) && run_bit && (service_interval != '0);

  always_ff @(posedge i_clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      state_reg <= ohc_pkg::OHC_STOP;
    end else begin
      unique case (state_reg)
        ohc_pkg::OHC_STOP: begin
          if (div_start) state_reg <= ohc_pkg::OHC_CALC;
          else if (run_bit) state_reg <= ohc_pkg::OHC_RUN;
        end
        ohc_pkg::OHC_CALC: begin
          if (!run_bit) state_reg <= ohc_pkg::OHC_STOP;
          else if (div_done) state_reg <= ohc_pkg::OHC_RUN;
        end
        ohc_pkg::OHC_RUN: if (!run_bit) state_reg <= ohc_pkg::OHC_STOP;
        default: state_reg <= ohc_pkg::OHC_STOP;
      endcase
    end
  end

  ohc_divmod #(
    .NW (ohc_pkg::OT_TOT_W),
    .DW (ohc_pkg::IV_TOT_W)
  ) u_divmod (
    .i_clk_sys  (i_clk_sys),
    .i_rst_n    (rst_n_s),
    .i_start    (div_start),
    .i_dividend (total_minutes),
    .i_divisor  (service_interval),
    .o_done     (div_done),
    .o_rem      (div_rem)
  );

  ohc_tick #(
    .W (ohc_pkg::TICK_W)
  ) u_tick (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (rst_n_s),
    .i_period  (P_MINUTE_CYCLES),
    .o_tick    (tick)
  );

  // ----------------------------------------------------------------
  // Retained time values
  // ----------------------------------------------------------------
  // These sit on the power-on reset only, so a system reset keeps them.
  always_ff @(posedge i_clk_sys or negedge por_n_s) begin
    if (!por_n_s) begin
      tot_hrs_reg <= '0;
      tot_min_reg <= '0;
    end else if (clr_rise) begin
      tot_hrs_reg <= '0;
      tot_min_reg <= '0;
    end else if (preset_wr) begin
      tot_hrs_reg <= (wdata_reg[16:0] > ohc_pkg::TOT_HRS_MAX) ? ohc_pkg::TOT_HRS_MAX
                                                               : wdata_reg[16:0];
      tot_min_reg <= clamp_min(wdata_reg[ohc_pkg::TOT_MIN_LSB +: 6]);
    end else if (tick && i_en && run_bit && !tot_sat) begin
      if (tot_min_reg == ohc_pkg::MIN_MAX) begin
        tot_min_reg <= '0;
        tot_hrs_reg <= tot_hrs_reg + 17'h00001;
      end else begin
        tot_min_reg <= tot_min_reg + 6'h01;
      end
    end
  end

  // Remaining time in minutes; the start-up result fits the offset phase.
  always_ff @(posedge i_clk_sys or negedge por_n_s) begin
    if (!por_n_s) begin
      remaining_time_reg <= '0;
    end else if (reload) begin
      remaining_time_reg <= service_interval;
    end else if (div_done && state_reg == ohc_pkg::OHC_CALC) begin
      remaining_time_reg <= service_interval - div_rem;
    end else if (state_reg == ohc_pkg::OHC_STOP && run_bit && service_interval == '0) begin
      remaining_time_reg <= '0;
    end else if (state_reg == ohc_pkg::OHC_RUN && tick && i_en && !i_rst_interval &&
                 !i_clr_all && remaining_time_reg != '0) begin
      remaining_time_reg <= remaining_time_reg - 20'h00001;
    end
  end

  // ----------------------------------------------------------------
  // Switch output and events
  // ----------------------------------------------------------------
  assign q_next = (state_reg == ohc_pkg::OHC_RUN) && (remaining_time_reg == '0) &&
                  !reload && !i_rst_interval && !i_clr_all &&
                  (i_en || !ctrl_reg[ohc_pkg::CTRL_MODE]);
  assign irq_evt = {tick && i_en && run_bit && !tot_sat && tot_min_reg == ohc_pkg::MIN_MAX &&
                    tot_hrs_reg == ohc_pkg::TOT_HRS_MAX - 17'h00001,
                    q_next && !o_q};

  always_ff @(posedge i_clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      o_q <= 1'b0;
    end else begin
      o_q <= q_next;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  always_comb begin
    rd_data = '0;
    unique case (i_araddr)
      ohc_pkg::OFF_CTRL:     rd_data[2:0] = ctrl_reg;
      ohc_pkg::OFF_INTERVAL: rd_data = {10'h000, iv_min, 2'h0, iv_hrs};
      ohc_pkg::OFF_TOTAL:    rd_data = {2'h0, tot_min_reg, 7'h00, tot_hrs_reg};
      ohc_pkg::OFF_REMAIN:   rd_data[19:0] = remaining_time_reg;
      ohc_pkg::OFF_STATUS:   rd_data[4:0] = {tot_sat, i_en, state_reg, o_q};
      ohc_pkg::OFF_IRQ_STAT: rd_data[1:0] = irq_stat_reg;
      ohc_pkg::OFF_IRQ_MASK: rd_data[1:0] = irq_mask_reg;
      default:               rd_data = '0;
    endcase
  end

  // One read at a time; the address is refused while data wait.
  always_ff @(posedge i_clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= '0;
      o_rresp   <= ohc_pkg::RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b1;
      o_rdata   <= rd_data;
      o_rresp   <= is_mapped(i_araddr) ? ohc_pkg::RESP_OKAY : ohc_pkg::RESP_SLVERR;
    end else if (o_rvalid && i_rready) begin
      o_rvalid  <= 1'b0;
      o_arready <= 1'b1;
    end
  end

endmodule : ohc_top
`default_nettype wire

//--- inc/ohc_pkg.sv
// Shared constants and types for the operating hours counter.
package ohc_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W       = 5;
  localparam logic [4:0]  OFF_CTRL     = 5'h00;
  localparam logic [4:0]  OFF_INTERVAL = 5'h04;
  localparam logic [4:0]  OFF_TOTAL    = 5'h08;
  localparam logic [4:0]  OFF_REMAIN   = 5'h0C;
  localparam logic [4:0]  OFF_STATUS   = 5'h10;
  localparam logic [4:0]  OFF_IRQ_STAT = 5'h14;
  localparam logic [4:0]  OFF_IRQ_MASK = 5'h18;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_MODE    = 0;
  localparam int unsigned CTRL_RUN     = 1;
  localparam int unsigned CTRL_EXT     = 2;
  localparam int unsigned IV_MIN_LSB   = 16;
  localparam int unsigned TOT_MIN_LSB  = 24;
  localparam int unsigned IRQ_ZERO     = 0;
  localparam int unsigned IRQ_SAT      = 1;
  localparam logic [2:0]  CTRL_RST     = 3'h0;
  localparam logic [1:0]  IRQ_MASK_RST = 2'h0;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // ----------------------------------------------------------------
  // Widths and limits of the time values
  // ----------------------------------------------------------------
  localparam int unsigned IV_HRS_W   = 14;
  localparam int unsigned TOT_HRS_W  = 17;
  localparam int unsigned MIN_W      = 6;
  localparam int unsigned IV_TOT_W   = 20;
  localparam int unsigned OT_TOT_W   = 23;
  localparam logic [13:0] IV_HRS_MAX  = 14'h270F;
  localparam logic [16:0] TOT_HRS_MAX = 17'h1869F;
  localparam logic [5:0]  MIN_MAX     = 6'h3B;

  // ----------------------------------------------------------------
  // Time base: one minute at the system clock rate
  // ----------------------------------------------------------------
  localparam longint unsigned MINUTE_S      = 60;
  localparam longint unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned     TICK_W        = 33;
  localparam logic [32:0]     MINUTE_CYCLES = 33'(MINUTE_S * CLK_HZ);

  typedef enum logic [1:0] {
    OHC_STOP = 2'b00,
    OHC_CALC = 2'b01,
    OHC_RUN  = 2'b11
  } ohc_state_e;

endpackage : ohc_pkg

//--- hw/ohc_tick.sv
// One-minute tick divider for the operating hours counter.
`timescale 1ns/100ps
`default_nettype none

module ohc_tick #(
  parameter int unsigned W = 33
) (
  input  wire logic         i_clk_sys, // System clock.
  input  wire logic         i_rst_n,   // Synchronised reset, active low.
  input  wire logic [W-1:0] i_period,  // Cycles per tick.
  output logic              o_tick     // One-cycle pulse per period.
);

  logic [W-1:0] cnt_reg;

  // Free-running count; the pulse comes from a flip-flop.
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= '0;
      o_tick  <= 1'b0;
    end else if (cnt_reg >= i_period - W'(1)) begin
      cnt_reg <= '0;
      o_tick  <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + W'(1);
      o_tick  <= 1'b0;
    end
  end

endmodule : ohc_tick
`default_nettype wire

//--- hw/ohc_divmod.sv
// Serial restoring remainder unit, one quotient bit per cycle.
`timescale 1ns/100ps
`default_nettype none

module ohc_divmod #(
  parameter int unsigned NW = 23,
  parameter int unsigned DW = 20
) (
  input  wire logic          i_clk_sys,  // System clock.
  input  wire logic          i_rst_n,    // Synchronised reset, active low.
  input  wire logic          i_start,    // Start pulse, takes operands.
  input  wire logic [NW-1:0] i_dividend, // Numerator.
  input  wire logic [DW-1:0] i_divisor,  // Non-zero divisor.
  output logic               o_done,     // One-cycle pulse, result valid.
  output logic [DW-1:0]      o_rem       // Remainder, registered.
);

  logic [NW-1:0] num_reg;
  logic [DW:0]   part_reg;
  logic [DW-1:0] div_reg;
  logic [5:0]    left_reg;
  logic [DW:0]   shifted;

  assign shifted = {part_reg[DW-1:0], num_reg[NW-1]};

  // Shift the numerator in MSB first and subtract when the divisor fits.
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      num_reg  <= '0;
      part_reg <= '0;
      div_reg  <= '0;
      left_reg <= '0;
      o_done   <= 1'b0;
      o_rem    <= '0;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        num_reg  <= i_dividend;
        div_reg  <= i_divisor;
        part_reg <= '0;
        left_reg <= 6'(NW);
      end else if (left_reg != 6'h00) begin
        num_reg  <= {num_reg[NW-2:0], 1'b0};
        part_reg <= (shifted >= {1'b0, div_reg}) ? shifted - {1'b0, div_reg} : shifted;
        left_reg <= left_reg - 6'h01;
        if (left_reg == 6'h01) begin
          o_done <= 1'b1;
          o_rem  <= (shifted >= {1'b0, div_reg}) ? DW'(shifted - {1'b0, div_reg})
                                                 : DW'(shifted);
        end
      end
    end
  end

endmodule : ohc_divmod
`default_nettype wire

//--- test/ohc_top_properties.sv
// Port-level assertions for the operating hours counter.
`timescale 1ns/100ps
`default_nettype none

module ohc_top_properties (
  input wire logic        i_clk_sys,      // Clock.
  input wire logic        i_rst_n,        // Reset, low.
  input wire logic        i_rst_interval, // Interval reset.
  input wire logic        i_clr_all,      // Clear-all.
  input wire logic        o_q,            // Output.
  input wire logic        i_arvalid,      // AR valid.
  input wire logic        o_arready,      // AR ready.
  input wire logic        o_rvalid,       // R valid.
  input wire logic        i_rready,       // R ready.
  input wire logic [31:0] o_rdata,        // R data.
  input wire logic        o_bvalid,       // B valid.
  input wire logic        i_bready,       // B ready.
  input wire logic [1:0]  o_bresp         // B response.
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  // Either reset input pulls the output down one cycle later.
  AST_Q_IV: assert property (i_rst_interval |=> !o_q) else $error("q after reset");
  AST_Q_CLR: assert property (i_clr_all |=> !o_q) else $error("q after clear");
  // Read answers come on time; read and write answers stand until taken, then drop.
  AST_RD_ANS: assert property (i_arvalid && o_arready |=> o_rvalid) else $error("no rvalid");
  AST_R_HOLD: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("rdata moved");
  AST_R_DONE: assert property (o_rvalid && i_rready |=> !o_rvalid) else $error("rvalid stuck");
  AST_AR_BLK: assert property (o_rvalid |-> !o_arready) else $error("arready with rvalid");
  AST_B_HOLD: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("bresp moved");
  AST_B_DONE: assert property (o_bvalid && i_bready |=> !o_bvalid) else $error("bvalid stuck");
  // Main scenarios.
  C_Q_RISE: cover property ($rose(o_q));
  C_Q_FALL: cover property ($fell(o_q) && i_rst_interval);
  C_WR: cover property (o_bvalid && i_bready);

endmodule : ohc_top_properties
`default_nettype wire

//--- test/ohc_prog_model.sv
// Program-logic model that drives the two reset inputs.
`timescale 1ns/100ps
`default_nettype none

module ohc_prog_model (
  input  wire logic i_clk_sys,      // Clock.
  input  wire logic i_go_iv,        // Request interval reset.
  input  wire logic i_go_clr,       // Request clear-all.
  output logic      o_rst_interval, // Interval reset.
  output logic      o_clr_all       // Clear-all.
);
  logic [2:0] iv_reg  = 3'h0;
  logic [2:0] clr_reg = 3'h0;

  // Each reset is held four cycles, as slow program logic would.
  always_ff @(posedge i_clk_sys) begin
    iv_reg  <= i_go_iv ? 3'h4 : iv_reg - 3'(iv_reg != 3'h0);
    clr_reg <= i_go_clr ? 3'h4 : clr_reg - 3'(clr_reg != 3'h0);
  end
  assign o_rst_interval = iv_reg != 3'h0;
  assign o_clr_all      = clr_reg != 3'h0;

endmodule : ohc_prog_model
`default_nettype wire

//--- test/test_ohc_top.sv
// Self-checking bench for the operating hours counter.
`timescale 1ns/100ps
`default_nettype none

module test_ohc_top;
  logic        i_clk_sys = 1'b0, i_rst_n = 1'b0, i_por_n = 1'b0, i_en = 1'b0;
  logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, go_iv = 1'b0;
  logic        i_arvalid = 1'b0, i_rready = 1'b0, go_clr = 1'b0;
  logic [4:0]  i_awaddr = 5'h00, i_araddr = 5'h00;
  logic [31:0] i_wdata = 32'h0, rd;
  logic [3:0]  i_wstrb = 4'hF;
  logic [13:0] i_ext_hours = 14'h0;
  logic [5:0]  i_ext_minutes = 6'h0;
  logic [1:0]  rsp;
  wire logic   i_rst_interval, i_clr_all, o_q, o_irq, o_awready, o_wready;
  wire logic   o_bvalid, o_arready, o_rvalid;
  wire logic [1:0]  o_bresp, o_rresp;
  wire logic [31:0] o_rdata;
  int          err_total = 0, tests_run = 0, seed = 32'hCF06, th, ih, k;

  always #4 i_clk_sys = ~i_clk_sys;

  // A ten-cycle minute keeps the countdowns short.
  ohc_top #(.P_MINUTE_CYCLES(33'hA)) ohc_top_inst (.i_clk_sys, .i_rst_n, .i_por_n, .i_en,
    .i_rst_interval, .i_clr_all, .i_ext_hours, .i_ext_minutes, .o_q, .o_irq, .i_awaddr,
    .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid,
    .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready);
  ohc_prog_model ohc_prog_model_inst (.i_clk_sys, .i_go_iv(go_iv), .i_go_clr(go_clr),
    .o_rst_interval(i_rst_interval), .o_clr_all(i_clr_all));

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Ready stands from the request on; only the watchdog ends a wait for the answer.
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    i_awaddr  <= a;
    i_wdata   <= d;
    i_awvalid <= 1'b1;
    i_wvalid  <= 1'b1;
    i_bready  <= 1'b1;
    do begin
      @(posedge i_clk_sys);
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
    end while (!o_bvalid);
    rsp = o_bresp;
    i_bready <= 1'b0;
    @(posedge i_clk_sys);
  endtask : wr

  task automatic rd_ck(input logic [4:0] a, input logic [31:0] exp, input string nm);
    i_araddr  <= a;
    i_arvalid <= 1'b1;
    i_rready  <= 1'b1;
    do begin
      @(posedge i_clk_sys);
      if (o_arready) i_arvalid <= 1'b0;
    end while (!o_rvalid);
    rd  = o_rdata;
    rsp = o_rresp;
    i_rready <= 1'b0;
    @(posedge i_clk_sys);
    check(nm, rd, exp);
  endtask : rd_ck

  function automatic logic [31:0] exp_remain(input int t, input int i);
    return 32'(i * 60 - (t * 60) % (i * 60));
  endfunction : exp_remain

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  // Main sequence: registers, start-up arithmetic, countdown, ceiling.
  initial begin
    repeat (16) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    i_por_n <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    rd_ck(ohc_pkg::OFF_CTRL, 32'h0, "ctrl reset");
    rd_ck(ohc_pkg::OFF_IRQ_MASK, 32'h0, "mask reset");
    rd_ck(5'h1C, 32'h0, "unmapped read");
    check("rresp", 32'(rsp), 32'(ohc_pkg::RESP_SLVERR));
    wr(5'h1C, 32'h0);
    check("bresp", 32'(rsp), 32'(ohc_pkg::RESP_SLVERR));
    i_ext_hours   <= 14'h3FFF;
    i_ext_minutes <= 6'h3F;
    wr(ohc_pkg::OFF_CTRL, 32'h4);
    rd_ck(ohc_pkg::OFF_INTERVAL, 32'h003B270F, "clamp");
    $display("test registers done");
    for (k = 0; k < 3; k++) begin
      th = $unsigned($random(seed)) % 1000;
      ih = 1 + $unsigned($random(seed)) % 99;
      if (k == 0) th = ih * 3;
      wr(ohc_pkg::OFF_CTRL, 32'h0);
      wr(ohc_pkg::OFF_TOTAL, 32'(th));
      wr(ohc_pkg::OFF_INTERVAL, 32'(ih));
      wr(ohc_pkg::OFF_CTRL, 32'h2);
      repeat (40) @(posedge i_clk_sys);
      rd_ck(ohc_pkg::OFF_REMAIN, exp_remain(th, ih), "start remain");
      repeat (40) @(posedge i_clk_sys);
      rd_ck(ohc_pkg::OFF_REMAIN, exp_remain(th, ih), "idle remain");
      wr(ohc_pkg::OFF_TOTAL, 32'h0);
      rd_ck(ohc_pkg::OFF_TOTAL, 32'(th), "no preset");
    end
    $display("test start done");
    wr(ohc_pkg::OFF_INTERVAL, 32'h00030000);
    go_clr <= 1'b1;
    @(posedge i_clk_sys);
    go_clr <= 1'b0;
    repeat (8) @(posedge i_clk_sys);
    rd_ck(ohc_pkg::OFF_TOTAL, 32'h0, "cleared total");
    rd_ck(ohc_pkg::OFF_REMAIN, 32'h3, "reloaded");
    wr(ohc_pkg::OFF_IRQ_MASK, 32'h1);
    i_en <= 1'b1;
    repeat (60) @(posedge i_clk_sys);
    check("q at zero", 32'(o_q), 32'h1);
    check("irq", 32'(o_irq), 32'h1);
    rd_ck(ohc_pkg::OFF_REMAIN, 32'h0, "floor");
    wr(ohc_pkg::OFF_IRQ_STAT, 32'h1);
    check("irq clear", 32'(o_irq), 32'h0);
    i_en <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    check("q mode0", 32'(o_q), 32'h1);
    wr(ohc_pkg::OFF_CTRL, 32'h3);
    check("q mode1", 32'(o_q), 32'h0);
    wr(ohc_pkg::OFF_CTRL, 32'h2);
    check("q back", 32'(o_q), 32'h1);
    go_iv <= 1'b1;
    @(posedge i_clk_sys);
    go_iv <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    check("q iv reset", 32'(o_q), 32'h0);
    repeat (8) @(posedge i_clk_sys);
    rd_ck(ohc_pkg::OFF_REMAIN, 32'h3, "iv reload");
    $display("test countdown done");
    wr(ohc_pkg::OFF_CTRL, 32'h0);
    wr(ohc_pkg::OFF_TOTAL, 32'h3B01869E);
    wr(ohc_pkg::OFF_CTRL, 32'h2);
    i_en <= 1'b1;
    repeat (60) @(posedge i_clk_sys);
    rd_ck(ohc_pkg::OFF_TOTAL, 32'h0001869F, "ceiling");
    rd_ck(ohc_pkg::OFF_STATUS, 32'h1F, "status");
    rd_ck(ohc_pkg::OFF_IRQ_STAT, 32'h3, "irq events");
    i_en    <= 1'b0;
    i_rst_n <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    rd_ck(ohc_pkg::OFF_TOTAL, 32'h0001869F, "retained");
    $display("test ceiling done");
    summarize();
  end

  // Watchdog: far beyond the several hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    err_total++;
    summarize();
  end

endmodule : test_ohc_top

bind ohc_top ohc_top_properties ohc_top_properties_inst (.i_clk_sys, .i_rst_n, .i_rst_interval,
  .i_clr_all, .o_q, .i_arvalid, .o_arready, .o_rvalid, .i_rready, .o_rdata, .o_bvalid,
  .i_bready, .o_bresp);
`default_nettype wire
